/* rtl/tcsi_pkg.sv */
package tcsi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CHANNEL_MODE = 8'h04;
  localparam logic [7:0] OFS_CHANNEL_STATUS = 8'h20;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_SET = 8'h24;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_CLEAR = 8'h28;
  localparam logic [7:0] OFS_INTERRUPT_MASK_VIEW = 8'h2c;

  // Status and mode field positions
  localparam int BIT_COUNTER_OVERFLOW = 0;
  localparam int BIT_LOAD_OVERRUN = 1;
  localparam int BIT_COMPARE_A_HIT = 2;
  localparam int BIT_COMPARE_B_HIT = 3;
  localparam int BIT_COMPARE_C_HIT = 4;
  localparam int BIT_LOAD_A = 5;
  localparam int BIT_LOAD_B = 6;
  localparam int BIT_EXT_TRIGGER = 7;
  localparam int BIT_CLOCK_RUNNING = 16;
  localparam int BIT_IO_A_MIRROR = 17;
  localparam int BIT_IO_B_MIRROR = 18;
  localparam int BIT_GENERATION_MODE = 0;

  // Mode select encoding
  localparam logic MODE_CAPTURE = 1'b0;
  localparam logic MODE_GENERATION = 1'b1;

  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic RST_MODE = 1'b0;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Flags that only count in generation or in capture mode
  localparam logic [7:0] GEN_ONLY_FLAGS = 8'h0c;
  localparam logic [7:0] CAP_ONLY_FLAGS = 8'h62;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic mode;
    logic [SYNC_STAGES-1:0] sync_a;
    logic [SYNC_STAGES-1:0] sync_b;
    logic pin_a;
    logic pin_b;
    logic clock_running;
    logic io_a_mirror;
    logic io_b_mirror;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } tcsi_state_s;

  typedef struct packed {
    logic pending;
  } tcsi_watch_s;

endpackage

/* rtl/tcsi_load_watch.sv */
`timescale 1ns/1ps
module tcsi_load_watch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic capture_mode_i,
  input wire logic load_i,
  input wire logic read_i,
  output logic overrun_o
);

  tcsi_pkg::tcsi_watch_s state;
  tcsi_pkg::tcsi_watch_s next_state;

  // Second load while the previous value is still unread
  always_comb begin
    next_state = state;
    overrun_o = capture_mode_i & load_i & state.pending & ~read_i;
    if (!capture_mode_i) begin
      next_state.pending = 1'b0;
    end else if (load_i) begin
      next_state.pending = 1'b1;
    end else if (read_i) begin
      next_state.pending = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

/* rtl/tcsi_channel.sv */
`timescale 1ns/1ps
module tcsi_channel #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic counter_overflow_i,
  input wire logic capture_a_load_i,
  input wire logic capture_b_load_i,
  input wire logic capture_a_read_i,
  input wire logic capture_b_read_i,
  input wire logic compare_a_hit_i,
  input wire logic compare_b_hit_i,
  input wire logic compare_c_hit_i,
  input wire logic ext_trigger_i,
  input wire logic clock_enabled_i,
  input wire logic io_line_a_pin_i,
  input wire logic io_line_b_pin_i,
  input wire logic io_line_a_drive_i,
  input wire logic io_line_b_drive_i,
  output logic generation_mode_o,
  output logic irq_o
);

  tcsi_pkg::tcsi_state_s state;
  tcsi_pkg::tcsi_state_s next_state;

  logic overrun_a;
  logic overrun_b;
  logic capture_mode;

  assign capture_mode = (state.mode == tcsi_pkg::MODE_CAPTURE);

  // Unread capture value trackers
  tcsi_load_watch u_watch_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .capture_mode_i(capture_mode),
    .load_i(capture_a_load_i),
    .read_i(capture_a_read_i),
    .overrun_o(overrun_a)
  );

  tcsi_load_watch u_watch_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .capture_mode_i(capture_mode),
    .load_i(capture_b_load_i),
    .read_i(capture_b_read_i),
    .overrun_o(overrun_b)
  );

  // Word address match
  function automatic logic addr_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
    logic [7:0] word;
    word = 8'(adr);
    addr_hit = (word[7:2] == ofs[7:2]);
  endfunction

  // Status word image
  function automatic logic [31:0] status_word(input tcsi_pkg::tcsi_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[7:0] = s.flags;
    w[tcsi_pkg::BIT_CLOCK_RUNNING] = s.clock_running;
    w[tcsi_pkg::BIT_IO_A_MIRROR] = s.io_a_mirror;
    w[tcsi_pkg::BIT_IO_B_MIRROR] = s.io_b_mirror;
    status_word = w;
  endfunction

  logic [7:0] events;
  logic [7:0] mode_gate;
  logic take;
  logic take_rd;
  logic take_wr;
  logic lane0;

  always_comb begin
    events = 8'h00;
    events[tcsi_pkg::BIT_COUNTER_OVERFLOW] = counter_overflow_i;
    events[tcsi_pkg::BIT_LOAD_OVERRUN] = overrun_a | overrun_b;
    events[tcsi_pkg::BIT_COMPARE_A_HIT] = compare_a_hit_i;
    events[tcsi_pkg::BIT_COMPARE_B_HIT] = compare_b_hit_i;
    events[tcsi_pkg::BIT_COMPARE_C_HIT] = compare_c_hit_i;
    events[tcsi_pkg::BIT_LOAD_A] = capture_a_load_i;
    events[tcsi_pkg::BIT_LOAD_B] = capture_b_load_i;
    events[tcsi_pkg::BIT_EXT_TRIGGER] = ext_trigger_i;
  end

  // Flags that may be nonzero in the current mode
  always_comb begin
    if (state.mode == tcsi_pkg::MODE_GENERATION) begin
      mode_gate = ~tcsi_pkg::CAP_ONLY_FLAGS;
    end else begin
      mode_gate = ~tcsi_pkg::GEN_ONLY_FLAGS;
    end
  end

  assign take = wb_cyc_i & wb_stb_i & ~state.ack;
  assign take_rd = take & ~wb_we_i;
  assign take_wr = take & wb_we_i;
  assign lane0 = wb_sel_i[0];

  always_comb begin
    next_state = state;
    next_state.ack = take;
    next_state.dat = tcsi_pkg::RST_DATA;

    // Pin synchronisers, change accepted when last two stages agree
    next_state.sync_a = {state.sync_a[tcsi_pkg::SYNC_STAGES-2:0], io_line_a_pin_i};
    next_state.sync_b = {state.sync_b[tcsi_pkg::SYNC_STAGES-2:0], io_line_b_pin_i};
    if (state.sync_a[2] == state.sync_a[1]) begin
      next_state.pin_a = state.sync_a[2];
    end
    if (state.sync_b[2] == state.sync_b[1]) begin
      next_state.pin_b = state.sync_b[2];
    end

    // Live status bits
    next_state.clock_running = clock_enabled_i;
    if (state.mode == tcsi_pkg::MODE_GENERATION) begin
      next_state.io_a_mirror = io_line_a_drive_i;
      next_state.io_b_mirror = io_line_b_drive_i;
    end else begin
      next_state.io_a_mirror = state.pin_a;
      next_state.io_b_mirror = state.pin_b;
    end

    // Read data and read side effects
    if (take_rd) begin
      if (addr_hit(wb_adr_i, tcsi_pkg::OFS_CHANNEL_STATUS)) begin
        next_state.dat = status_word(state);
        next_state.flags = 8'h00;
      end else if (addr_hit(wb_adr_i, tcsi_pkg::OFS_INTERRUPT_MASK_VIEW)) begin
        next_state.dat = {24'h00_0000, state.mask};
      end else if (addr_hit(wb_adr_i, tcsi_pkg::OFS_CHANNEL_MODE)) begin
        next_state.dat = {31'h0000_0000, state.mode};
      end
    end

    // Writes
    if (take_wr && lane0) begin
      if (addr_hit(wb_adr_i, tcsi_pkg::OFS_INTERRUPT_ENABLE_SET)) begin
        next_state.mask = state.mask | wb_dat_i[7:0];
      end else if (addr_hit(wb_adr_i, tcsi_pkg::OFS_INTERRUPT_ENABLE_CLEAR)) begin
        next_state.mask = state.mask & ~wb_dat_i[7:0];
      end else if (addr_hit(wb_adr_i, tcsi_pkg::OFS_CHANNEL_STATUS)) begin
        next_state.flags = state.flags & ~wb_dat_i[7:0];
      end else if (addr_hit(wb_adr_i, tcsi_pkg::OFS_CHANNEL_MODE)) begin
        next_state.mode = wb_dat_i[tcsi_pkg::BIT_GENERATION_MODE];
      end
    end

    // New events win over any clear in the same cycle
    next_state.flags = (next_state.flags | (events & mode_gate)) & mode_gate;

    next_state.irq = |(next_state.flags & next_state.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.flags <= tcsi_pkg::RST_FLAGS;
      state.mask <= tcsi_pkg::RST_MASK;
      state.mode <= tcsi_pkg::RST_MODE;
      state.sync_a <= '0;
      state.sync_b <= '0;
      state.pin_a <= 1'b0;
      state.pin_b <= 1'b0;
      state.clock_running <= 1'b0;
      state.io_a_mirror <= 1'b0;
      state.io_b_mirror <= 1'b0;
      state.ack <= 1'b0;
      state.dat <= tcsi_pkg::RST_DATA;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o = state.dat;
  assign wb_ack_o = state.ack;
  assign generation_mode_o = state.mode;
  assign irq_o = state.irq;

endmodule

/* verification/tcsi_channel_monitor.sv */
`timescale 1ns/1ps
module tcsi_channel_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic counter_overflow_i,
  input wire logic clock_enabled_i,
  input wire logic generation_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic rs;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign rs = rd && wb_adr_i == ADDR_W'(8'h20);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
  a_ovf_seen: assert property (counter_overflow_i ##1 rs |=> wb_dat_o[0])
    else $error("overflow flag lost");
  a_clock_live: assert property (rs && $stable(clock_enabled_i) && !$past(rst_i)
    |=> wb_dat_o[16] == $past(clock_enabled_i)) else $error("clock state wrong");
  a_cmp_gated: assert property (rs && !generation_mode_o && !$past(generation_mode_o)
    |=> wb_dat_o[3:2] == 2'b00) else $error("compare flag in capture mode");
  a_load_gated: assert property (rs && generation_mode_o && $past(generation_mode_o)
    |=> wb_dat_o[6:5] == 2'b00 && !wb_dat_o[1]) else $error("load flag in generation mode");
  a_wo_zero: assert property (rd && (wb_adr_i == ADDR_W'(8'h24) || wb_adr_i == ADDR_W'(8'h28))
    |=> wb_dat_o == 32'h0000_0000) else $error("write-only reads nonzero");
  a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:19] == 13'h0000 && wb_dat_o[15:8] == 8'h00)
    else $error("unused bits set");
  cover property (counter_overflow_i ##1 rs);
  cover property (rs && generation_mode_o);
  cover property (rs && !generation_mode_o);
endmodule
bind tcsi_channel tcsi_channel_monitor #(.ADDR_W(ADDR_W)) tcsi_channel_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .counter_overflow_i(counter_overflow_i), .clock_enabled_i(clock_enabled_i),
  .generation_mode_o(generation_mode_o));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, gen_o, m_gen, ua, ub, ov, tk, m_irq = 1'b0;
  logic [7:0] adr = 8'h00, m_fl, m_mk, e;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, rdv, exp_rd, snap, r, s = 32'hf026_cf17;
  logic [8:0] ev = 9'h000;
  logic [4:0] lv = 5'h00;
  int err_total = 0, check_count = 0;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  tcsi_channel tcsi_channel_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .counter_overflow_i(ev[0]),
    .capture_a_load_i(ev[1]), .capture_b_load_i(ev[2]), .capture_a_read_i(ev[3]), .capture_b_read_i(ev[4]),
    .compare_a_hit_i(ev[5]), .compare_b_hit_i(ev[6]), .compare_c_hit_i(ev[7]), .ext_trigger_i(ev[8]),
    .clock_enabled_i(lv[0]), .io_line_a_pin_i(lv[1]), .io_line_b_pin_i(lv[2]), .io_line_a_drive_i(lv[3]),
    .io_line_b_drive_i(lv[4]), .generation_mode_o(gen_o), .irq_o(irq));
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, sl};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdv = dat_o;
    {cyc, stb} <= 2'b00;
    if (!w) chk(rdv, exp_rd);
    @(posedge clk_i);
  endtask
  // Reference model, updated at every edge
  always @(posedge clk_i) begin
    if (!rst_i) begin
      chk({31'h0, irq}, {31'h0, m_irq});
      chk({31'h0, gen_o}, {31'h0, m_gen});
    end
    tk = cyc && stb && !ack;
    ov = !m_gen && ((ev[1] && ua && !ev[3]) || (ev[2] && ub && !ev[4]));
    ua = !m_gen && (ev[1] || (ua && !ev[3]));
    ub = !m_gen && (ev[2] || (ub && !ev[4]));
    e = {ev[8], ev[2] & !m_gen, ev[1] & !m_gen, ev[7], ev[6] & m_gen, ev[5] & m_gen, ov, ev[0]};
    snap = {13'h0, m_gen ? lv[4:3] : lv[2:1], lv[0], 8'h00, m_fl};
    if (tk && !we) exp_rd = adr == 8'h20 ? snap : adr == 8'h2c ? {24'h0, m_mk} : adr == 8'h04 ? {31'h0, m_gen} : '0;
    if (tk && !we && adr == 8'h20) m_fl = 8'h00;
    if (tk && we && sel[0] && adr == 8'h20) m_fl = m_fl & ~dat[7:0];
    m_fl = (m_fl | e) & ~(m_gen ? 8'h62 : 8'h0c);
    if (tk && we && sel[0]) begin
      m_mk = adr == 8'h24 ? m_mk | dat[7:0] : adr == 8'h28 ? m_mk & ~dat[7:0] : m_mk;
      m_gen = adr == 8'h04 ? dat[0] : m_gen;
    end
    m_irq = |(m_fl & m_mk);
    if (rst_i) {m_fl, m_mk, m_gen, ua, ub, m_irq} = '0;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 8'h2c, 0, 4'hf);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        lv <= 5'(xs());
        bus(1, 8'h04, m, 4'hf);
        bus(0, 8'h04, 0, 4'hf);
        bus(1, 8'h24, xs(), 4'he);
        bus(1, 8'h24, xs(), 4'hf);
        bus(1, 8'h28, xs(), 4'hf);
        bus(0, 8'h2c, 0, 4'hf);
        repeat (24) begin
          r = xs() & xs();
          ev <= {r[8:5], r[4] & ~r[2], r[3] & ~r[1], r[2:0]};
          @(posedge clk_i);
        end
        bus(1, 8'h20, xs(), 4'hf);
        ev <= {r[8:5], 2'b00, r[2:0]};
        bus(0, 8'h20, 0, 4'hf);
        ev <= 9'h000;
        bus(0, 8'h20, 0, 4'hf);
        bus(0, i % 3 == 2 ? 8'h3c : 8'h24 + 8'(4 * (i % 3)), 0, 4'hf);
      end
    end
    finish_test;
  end
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
endmodule
